/* src/codec_frame_port.sv */
// Codec frame port master: bit clock, frame sync, shifter and sample FIFOs
// How it works
// [R1] Frame is 128 bits, two 64-bit subframes
// [R2] Rate select picks lower or higher bit clock
// [R3] Bit clock is oscillator times 13, /5 or /4
// [R4] External pin clock may drive the link instead
// [R5] Only subframe 0 carries traffic
// [R6] Seven fields travel each way in subframe 0
// [R7] 7-bit divisors load modulus counters on enable
// [R8] Four 8x16 sample FIFOs, two each direction
// [R9] 21-bit command and 21-bit read result registers
// [R10] After reset disabled, pins released as inputs
// [R11] Software clears status, writes enable last
// [R12] Frame sync one period, rising with bit clock
// [R13] Sync in bit 128, frames back to back
// [R14] Sync edge loads FIFO samples, sets valids
// [R15] Pending register access goes into the shifter
// [R16] Fields without new content repeat last value
// [R17] Frames continue while enabled, even empty
// [R18] Drive on rising edge, sample on falling
// [R19] Shift out MSB first, receive into LSB
// [R20] After 64 bits unpack received fields
// [R21] Transmit line low when not shifting
// [R22] Codec port owns pins over alternate port
// [R23] Valid received samples go into receive FIFOs
// [R24] Rate counters reload on enable or zero
// [R25] Field positions fixed by layout constants
`timescale 1ns/1ps
`include "codec_frame_consts.svh"

// Sample FIFO, flip-flop storage addressed by read and write index
module sample_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input  wire logic             clock_i,
  input  wire logic             sys_rst_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_idx;
  logic [AW-1:0]    rd_idx;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  // Honest full and empty straight from the occupancy count
  assign in_ready_o  = (count != (AW+1)'(DEPTH));
  assign out_valid_o = (count != '0);
  assign out_data_o  = mem[rd_idx];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_ready_i && out_valid_o;

  // Storage write
  always_ff @(posedge clock_i) begin
    if (push) begin
      mem[wr_idx] <= in_data_i;
    end
  end

  // Indices wrap at the depth, which need not be a power of two
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      wr_idx <= '0;
      rd_idx <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_idx <= (wr_idx == AW'(DEPTH-1)) ? '0 : wr_idx + 1'b1;
      end
      if (pop) begin
        rd_idx <= (rd_idx == AW'(DEPTH-1)) ? '0 : rd_idx + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : sample_fifo

module codec_frame_port #(
  parameter int FIFO_DEPTH = 8,
  parameter int DIV_WIDTH  = 7
) (
  input  wire logic                        clock_i,
  input  wire logic                        sys_rst_i,
  // Control
  input  wire logic                        enable_i,
  input  wire logic                        alt_sync_serial_en_i,
  input  wire logic                        ext_clk_sel_i,
  input  wire logic                        high_rate_sel_i,
  input  wire logic                        audio_en_i,
  input  wire logic                        telecom_en_i,
  input  wire logic [DIV_WIDTH-1:0]        audio_div_i,
  input  wire logic [DIV_WIDTH-1:0]        telecom_div_i,
  // Codec register access
  input  wire logic                        cmd_write_i,
  input  wire codec_frame_pkg::reg_access_t cmd_i,
  output logic                             cmd_pending_o,
  output codec_frame_pkg::reg_access_t     resp_o,
  output logic                             resp_valid_o,
  input  wire logic                        resp_ack_i,
  // Transmit sample streams
  input  wire logic                        audio_tx_valid_i,
  output logic                             audio_tx_ready_o,
  input  wire logic [15:0]                 audio_tx_data_i,
  input  wire logic                        tel_tx_valid_i,
  output logic                             tel_tx_ready_o,
  input  wire logic [15:0]                 tel_tx_data_i,
  // Receive sample streams
  output logic                             audio_rx_valid_o,
  input  wire logic                        audio_rx_ready_i,
  output logic [15:0]                      audio_rx_data_o,
  output logic                             tel_rx_valid_o,
  input  wire logic                        tel_rx_ready_i,
  output logic [15:0]                      tel_rx_data_o,
  output logic                             rx_overrun_o,
  output logic [1:0]                       rate_tick_o,
  // Pins
  input  wire logic                        ext_bit_clk_i,
  input  wire logic                        rx_serial_in_i,
  output logic                             sclk_o,
  output logic                             sclk_oe_o,
  output logic                             frame_sync_pin_o,
  output logic                             frame_sync_pin_oe_o,
  output logic                             tx_serial_out_o,
  output logic                             tx_serial_out_oe_o,
  output logic                             pins_to_alt_o,
  output logic                             pins_to_pin_share_o
);
  localparam logic [27:0] CLK_HZ = 28'(`CFP_SYS_CLK_HZ);
  localparam logic [27:0] INC_LO = 28'((2 * `CFP_OSC_HZ * `CFP_OSC_MULT)
                                       / `CFP_DIV_LOW_RATE); // R3
  localparam logic [27:0] INC_HI = 28'((2 * `CFP_OSC_HZ * `CFP_OSC_MULT)
                                       / `CFP_DIV_HIGH_RATE); // R3

  codec_frame_pkg::link_state_t state;
  logic [27:0]  phase_acc;
  logic [28:0]  next_acc;
  logic         int_clk;
  logic         int_rise;
  logic         int_fall;
  logic [2:0]   ext_sync;
  logic [1:0]   rx_sync;
  logic         bit_rise;
  logic         bit_fall;
  logic [6:0]   bit_cnt;
  logic [6:0]   next_bit;
  logic [63:0]  shifter;
  logic [63:0]  tx_hold;
  logic [63:0]  next_frame;
  logic         last_was_read;
  codec_frame_pkg::reg_access_t cmd_reg;
  codec_frame_pkg::sample_t     rx_audio;
  codec_frame_pkg::sample_t     rx_tel;
  logic         load_evt;
  logic         unpack_evt;
  logic [3:0]   f_in_valid;
  logic [3:0]   f_in_ready;
  logic [15:0]  f_in_data [4];
  logic [3:0]   f_out_valid;
  logic [3:0]   f_out_ready;
  logic [15:0]  f_out_data [4];
  logic [1:0]   sec_en;
  logic [1:0]   sec_en_d;
  logic [DIV_WIDTH-1:0] divisor [2];

  // Internal bit clock: phase accumulator at twice the bit rate
  assign next_acc = {1'b0, phase_acc}
                    + {1'b0, (high_rate_sel_i ? INC_HI : INC_LO)}; // R2
  assign int_rise = (next_acc >= {1'b0, CLK_HZ}) && !int_clk;
  assign int_fall = (next_acc >= {1'b0, CLK_HZ}) && int_clk;

  always_ff @(posedge clock_i) begin
    if (sys_rst_i || state == codec_frame_pkg::LINK_IDLE) begin
      phase_acc <= `CFP_ACC_RESET;
      int_clk   <= 1'b0;
    end else if (next_acc >= {1'b0, CLK_HZ}) begin
      phase_acc <= 28'(next_acc - {1'b0, CLK_HZ});
      int_clk   <= !int_clk;
    end else begin
      phase_acc <= next_acc[27:0];
    end
  end

  // Pin inputs pass two flops; edges only look past the first
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      ext_sync <= 3'h0;
      rx_sync  <= 2'h0;
    end else begin
      ext_sync <= {ext_sync[1:0], ext_bit_clk_i}; // R4
      rx_sync  <= {rx_sync[0], rx_serial_in_i};
    end
  end

  // Clock source select; edges only count while running
  always_comb begin
    if (state != codec_frame_pkg::LINK_RUN) begin
      bit_rise = 1'b0;
      bit_fall = 1'b0;
    end else if (ext_clk_sel_i) begin
      bit_rise = ext_sync[1] && !ext_sync[2]; // R4
      bit_fall = !ext_sync[1] && ext_sync[2];
    end else begin
      bit_rise = int_rise; // R2
      bit_fall = int_fall;
    end
  end

  // Run state; enabling presets the counter so the first rise syncs
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      state <= codec_frame_pkg::LINK_IDLE; // R10
    end else begin
      unique case (state)
        codec_frame_pkg::LINK_IDLE: begin
          if (enable_i) begin
            state <= codec_frame_pkg::LINK_RUN;
          end
        end
        codec_frame_pkg::LINK_RUN: begin
          if (!enable_i) begin
            state <= codec_frame_pkg::LINK_IDLE;
          end
        end
      endcase
    end
  end

  assign next_bit   = bit_cnt + 7'h01; // R1
  assign load_evt   = bit_rise && (next_bit == `CFP_LAST_BIT); // R14
  assign unpack_evt = bit_rise && (next_bit == `CFP_UNPACK_BIT); // R20

  // Bit counter wraps at 128; frames never stop while enabled
  always_ff @(posedge clock_i) begin
    if (sys_rst_i || state == codec_frame_pkg::LINK_IDLE) begin
      bit_cnt <= `CFP_PRELOAD_BIT; // R12
    end else if (bit_rise) begin
      bit_cnt <= next_bit; // R13 R17
    end
  end

  // Pins: sync and data change on rising bit edges and clear when idle; the clock rises and falls with the bit edges and falls when idle
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      sclk_o           <= 1'b0;
      frame_sync_pin_o <= 1'b0;
      tx_serial_out_o  <= 1'b0;
    end else begin
      if (bit_rise) begin
        sclk_o <= 1'b1;
      end else if (bit_fall || state == codec_frame_pkg::LINK_IDLE) begin
        sclk_o <= 1'b0;
      end
      if (state == codec_frame_pkg::LINK_IDLE) begin
        frame_sync_pin_o <= 1'b0;
        tx_serial_out_o  <= 1'b0; // R21
      end else if (bit_rise) begin
        frame_sync_pin_o <= (next_bit == `CFP_LAST_BIT); // R12 R13
        // Only bits 0..63 carry data, subframe 1 stays low
        tx_serial_out_o  <= !next_bit[6] && shifter[63]; // R5 R19 R21 R18
      end
    end
  end

  // Pin ownership: released until enabled, to the alternate port if it is enabled, else to the pin controller
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      sclk_oe_o           <= 1'b0; // R10
      frame_sync_pin_oe_o <= 1'b0;
      tx_serial_out_oe_o  <= 1'b0;
      pins_to_alt_o       <= 1'b0;
      pins_to_pin_share_o <= 1'b1;
    end else begin
      sclk_oe_o           <= enable_i;
      frame_sync_pin_oe_o <= enable_i;
      tx_serial_out_oe_o  <= enable_i;
      pins_to_alt_o       <= alt_sync_serial_en_i && !enable_i; // R22
      pins_to_pin_share_o <= !enable_i && !alt_sync_serial_en_i;
    end
  end

  // Build the outgoing subframe from new content or last frame's
  always_comb begin
    next_frame = tx_hold; // R16
    if (f_out_valid[0]) begin
      next_frame[`CFP_AUDIO_LSB +: 16] = f_out_data[0]; // R14 R25
    end
    if (f_out_valid[1]) begin
      next_frame[`CFP_TELECOM_LSB +: 16] = f_out_data[1]; // R14
    end
    // Valid flags mark new samples only
    next_frame[`CFP_AUDIO_VALID_BIT] = f_out_valid[0]; // R6 R14
    next_frame[`CFP_TEL_VALID_BIT]   = f_out_valid[1];
    if (cmd_pending_o) begin
      next_frame[`CFP_RW_BIT]               = cmd_reg.write; // R15
      next_frame[`CFP_ADDR_LSB +: 4]        = cmd_reg.addr;
      next_frame[`CFP_REG_DATA_LSB +: 16]   = cmd_reg.data;
    end
  end

  // Transmit FIFOs drain only at the sync load
  assign f_out_ready[0] = load_evt;
  assign f_out_ready[1] = load_evt;

  // Shifter: load on sync, shift on falling edges of subframe 0
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      shifter <= `CFP_SHIFT_RESET;
      tx_hold <= `CFP_SHIFT_RESET;
    end else if (load_evt) begin
      shifter <= next_frame; // R14 R15
      tx_hold <= next_frame; // R16
    end else if (bit_fall && !bit_cnt[6]) begin
      shifter <= {shifter[62:0], rx_sync[1]}; // R18 R19
    end
  end

  // Command register; a new write while pending replaces it
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      cmd_reg       <= '0;
      cmd_pending_o <= 1'b0;
      last_was_read <= 1'b0;
    end else begin
      if (cmd_write_i) begin
        cmd_reg       <= cmd_i; // R9
        cmd_pending_o <= 1'b1;
      end else if (load_evt && cmd_pending_o) begin
        cmd_pending_o <= 1'b0; // R15
      end
      if (load_evt) begin
        last_was_read <= cmd_pending_o && !cmd_reg.write;
      end
    end
  end

  // Received fields after bit 63
  assign rx_audio = '{valid: shifter[`CFP_AUDIO_VALID_BIT],
                      data:  shifter[`CFP_AUDIO_LSB +: 16]};
  assign rx_tel   = '{valid: shifter[`CFP_TEL_VALID_BIT],
                      data:  shifter[`CFP_TELECOM_LSB +: 16]};

  // Read result capture; a new capture wins over the ack
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      resp_o       <= '0;
      resp_valid_o <= 1'b0;
    end else if (unpack_evt && last_was_read) begin
      resp_o       <= '{write: shifter[`CFP_RW_BIT],
                        addr:  shifter[`CFP_ADDR_LSB +: 4],
                        data:  shifter[`CFP_REG_DATA_LSB +: 16]}; // R9 R20
      resp_valid_o <= 1'b1;
    end else if (resp_ack_i) begin
      resp_valid_o <= 1'b0;
    end
  end

  // Receive pushes; a full FIFO cannot stall the link, so flag it
  assign f_in_valid[2] = unpack_evt && rx_audio.valid; // R23
  assign f_in_valid[3] = unpack_evt && rx_tel.valid; // R23
  assign f_in_data[2]  = rx_audio.data;
  assign f_in_data[3]  = rx_tel.data;

  always_ff @(posedge clock_i) begin
    if (sys_rst_i || !enable_i) begin
      rx_overrun_o <= 1'b0;
    end else if ((f_in_valid[2] && !f_in_ready[2])
                 || (f_in_valid[3] && !f_in_ready[3])) begin
      rx_overrun_o <= 1'b1;
    end
  end

  // Transmit writes come from the user side
  assign f_in_valid[0]    = audio_tx_valid_i;
  assign f_in_valid[1]    = tel_tx_valid_i;
  assign f_in_data[0]     = audio_tx_data_i;
  assign f_in_data[1]     = tel_tx_data_i;
  assign audio_tx_ready_o = f_in_ready[0];
  assign tel_tx_ready_o   = f_in_ready[1];
  assign f_out_ready[2]   = audio_rx_ready_i;
  assign f_out_ready[3]   = tel_rx_ready_i;
  assign audio_rx_valid_o = f_out_valid[2];
  assign tel_rx_valid_o   = f_out_valid[3];
  assign audio_rx_data_o  = f_out_data[2];
  assign tel_rx_data_o    = f_out_data[3];

  // Four sample FIFOs: audio tx, telecom tx, audio rx, telecom rx
  for (genvar i = 0; i < 4; i++) begin : g_fifo
    sample_fifo #(
      .WIDTH (16),
      .DEPTH (FIFO_DEPTH)
    ) u_fifo (
      .clock_i     (clock_i),
      .sys_rst_i   (sys_rst_i),
      .in_valid_i  (f_in_valid[i]),
      .in_ready_o  (f_in_ready[i]),
      .in_data_i   (f_in_data[i]),
      .out_valid_o (f_out_valid[i]),
      .out_ready_i (f_out_ready[i]),
      .out_data_o  (f_out_data[i])
    ); // R8
  end

  // Sample-rate counters: reload on section enable or at zero
  assign sec_en     = {telecom_en_i, audio_en_i};
  assign divisor[0] = audio_div_i;
  assign divisor[1] = telecom_div_i;

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      sec_en_d <= 2'h0;
    end else begin
      sec_en_d <= sec_en;
    end
  end

  for (genvar s = 0; s < 2; s++) begin : g_rate
    logic [DIV_WIDTH-1:0] modulus;
    always_ff @(posedge clock_i) begin
      if (sys_rst_i || !sec_en[s]) begin
        modulus        <= '0;
        rate_tick_o[s] <= 1'b0;
      end else if (!sec_en_d[s]) begin
        modulus        <= divisor[s]; // R7 R24
        rate_tick_o[s] <= 1'b0;
      end else if (bit_rise) begin
        rate_tick_o[s] <= (modulus == '0);
        modulus <= (modulus == '0) ? divisor[s] : modulus - 1'b1; // R24
      end else begin
        rate_tick_o[s] <= 1'b0;
      end
    end
  end

  // Checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_sync_rise;
    $rose(frame_sync_pin_o);
  endsequence

  a_sync_on_rise: assert property (s_sync_rise |-> $rose(sclk_o)) // R12
    else $error("frame sync rose without bit clock rising");
  a_sync_width: assert property (bit_rise && frame_sync_pin_o // R12
                                 |=> !frame_sync_pin_o)
    else $error("frame sync held beyond one bit period");
  a_sync_last_bit: assert property (frame_sync_pin_o // R13
                                    |-> bit_cnt == `CFP_LAST_BIT)
    else $error("frame sync outside the last bit");
  a_tx_quiet: assert property (bit_cnt[6] && !frame_sync_pin_o // R21
                               |-> !tx_serial_out_o)
    else $error("tx line high outside subframe 0");
  a_tx_msb_first: assert property (bit_rise && next_bit == 7'h00 // R19
                                   |=> tx_serial_out_o == $past(shifter[63]))
    else $error("first data bit is not the shifter msb");
  // A new audio sample must land in its field with its valid flag set
  a_load_frame: assert property (load_evt && f_out_valid[0] // R14
                                 |=> shifter[`CFP_AUDIO_VALID_BIT]
                                 && shifter[`CFP_AUDIO_LSB +: 16]
                                 == $past(f_out_data[0]))
    else $error("shifter not loaded at frame sync");
  a_idle_pins: assert property (!enable_i ##1 !enable_i // R10
                                |-> !tx_serial_out_oe_o && !sclk_oe_o)
    else $error("pins driven while disabled");
  a_pin_owner: assert property (enable_i && alt_sync_serial_en_i // R22
                                |=> !pins_to_alt_o)
    else $error("alternate port got pins while codec port enabled");
  a_cmd_sent: assert property (load_evt && cmd_pending_o // R15
                               |=> !cmd_pending_o && tx_hold[`CFP_RW_BIT]
                               == $past(cmd_reg.write)
                               && tx_hold[`CFP_ADDR_LSB +: 4]
                               == $past(cmd_reg.addr))
    else $error("pending command not placed in the frame");
  // The push must leave the receive FIFO holding an entry
  a_rx_push: assert property (unpack_evt && rx_audio.valid // R23
                              && f_in_ready[2] |=> f_out_valid[2])
    else $error("valid audio sample not pushed");
endmodule : codec_frame_port

/* src/codec_frame_consts.svh */
// Constants of the codec frame port: timing, frame layout and reset values
`ifndef CODEC_FRAME_CONSTS_SVH
`define CODEC_FRAME_CONSTS_SVH

// Frame geometry
`define CFP_FRAME_BITS      128
`define CFP_SUBFRAME_BITS   64
`define CFP_LAST_BIT        7'h7F
`define CFP_PRELOAD_BIT     7'h7E
`define CFP_UNPACK_BIT      7'h40

// Bit clock derivation, frequencies in Hz
`define CFP_SYS_CLK_HZ      250000000
`define CFP_OSC_HZ          3686400
`define CFP_OSC_MULT        13
`define CFP_DIV_LOW_RATE    5
`define CFP_DIV_HIGH_RATE   4

// Subframe 0 field layout (bit 63 leaves first)
`define CFP_AUDIO_LSB       48
`define CFP_TELECOM_LSB     32
`define CFP_AUDIO_VALID_BIT 31
`define CFP_TEL_VALID_BIT   30
`define CFP_RW_BIT          29
`define CFP_ADDR_LSB        25
`define CFP_REG_DATA_LSB    9

// Reset values
`define CFP_SHIFT_RESET     64'h0000_0000_0000_0000
`define CFP_ACC_RESET       28'h000_0000

`endif

/* src/codec_frame_pkg.sv */
// Types shared by the codec frame port
package codec_frame_pkg;

  // One codec register access: read/write flag, address and data
  typedef struct packed {
    logic        write;
    logic [3:0]  addr;
    logic [15:0] data;
  } reg_access_t;

  // One audio or telecom sample with its valid flag
  typedef struct packed {
    logic        valid;
    logic [15:0] data;
  } sample_t;

  // Link engine state
  typedef enum logic [0:0] {
    LINK_IDLE = 1'b0,
    LINK_RUN  = 1'b1
  } link_state_t;

endpackage : codec_frame_pkg

/* test/codec_link_model.sv */
// Behavioural codec standing on the far side of the frame link
`timescale 1ns/1ps
module codec_link_model (
  input  wire logic        sclk_i,
  input  wire logic        fsync_i,
  input  wire logic        tx_i,
  input  wire logic [63:0] reply_i,
  output logic             rx_o,
  output logic [63:0]      got_o,
  output logic             sub1_high_o,
  output int               frames_o,
  output int               frame_bits_o,
  output real              frame_ns_o
);
  int          idx;
  int          cnt;
  real         t_sync;
  logic [63:0] sh;

  initial begin
    idx = 0;
    cnt = 0;
    t_sync = 0.0;
    rx_o = 1'b0;
    sh = '0;
    got_o = '0;
    sub1_high_o = 1'b0;
    frames_o = 0;
    frame_bits_o = 0;
    frame_ns_o = 0.0;
  end

  // Latch on the falling edge; sync marks the last bit of a frame
  always @(negedge sclk_i) begin
    if (fsync_i) begin
      frame_bits_o = cnt;
      frame_ns_o = $realtime - t_sync;
      t_sync = $realtime;
      cnt = 1;
      idx = 64;
    end else begin
      cnt = cnt + 1;
      if (idx > 0) begin
        sh[idx-1] = tx_i;
        idx = idx - 1;
        if (idx == 0) begin
          got_o = sh;
          frames_o = frames_o + 1;
        end
      end else if (tx_i) begin
        sub1_high_o = 1'b1;
      end
    end
  end

  // Reply bits change on the rising edge; line driven low outside subframe 0
  always @(posedge sclk_i) begin
    rx_o <= (idx > 0) ? reply_i[idx-1] : 1'b0;
  end
endmodule : codec_link_model

/* test/codec_frame_port_bench.sv */
// Self-checking bench for the codec frame port master
`timescale 1ns/1ps
`include "codec_frame_consts.svh"
module codec_frame_port_bench;
  logic        clock_i, sys_rst_i, enable_i, alt_en, hi_rate, sec_en;
  logic        ext_sel, ext_clk;
  logic        cmd_wr, ack, atv, ttv, arr, trr;
  logic [15:0] atd, ttd;
  logic        cmd_pend, resp_v, atr, ttr, arv, trv, ovr, sclk, sclk_oe;
  logic        fs, fs_oe, txd, tx_oe, p_alt, p_share, rxd, sub1;
  logic [15:0] ard, trd;
  logic [1:0]  tick;
  logic [63:0] got;
  int          frames, fbits, err_count, tests_run, ticks;
  real         fns;
  codec_frame_pkg::reg_access_t cmd, resp;
  localparam logic [63:0] REPLY = {16'hA5C3, 16'h3C5A, 3'b110, 4'h9,
                                   16'hBEEF, 9'h000};
  localparam logic [63:0] EXP1  = {16'h1234, 16'h5678, 3'b110, 4'h5,
                                   16'h0000, 9'h000};
  localparam logic [63:0] EXP2  = {16'h1234, 16'h5678, 3'b001, 4'hA,
                                   16'hC0DE, 9'h000};

  codec_frame_port codec_frame_port_inst (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .enable_i(enable_i),
    .alt_sync_serial_en_i(alt_en), .ext_clk_sel_i(ext_sel),
    .high_rate_sel_i(hi_rate), .audio_en_i(sec_en), .telecom_en_i(sec_en),
    .audio_div_i(7'h06), .telecom_div_i(7'h10), .cmd_write_i(cmd_wr),
    .cmd_i(cmd), .cmd_pending_o(cmd_pend), .resp_o(resp),
    .resp_valid_o(resp_v), .resp_ack_i(ack), .audio_tx_valid_i(atv),
    .audio_tx_ready_o(atr), .audio_tx_data_i(atd), .tel_tx_valid_i(ttv),
    .tel_tx_ready_o(ttr), .tel_tx_data_i(ttd), .audio_rx_valid_o(arv),
    .audio_rx_ready_i(arr), .audio_rx_data_o(ard), .tel_rx_valid_o(trv),
    .tel_rx_ready_i(trr), .tel_rx_data_o(trd), .rx_overrun_o(ovr),
    .rate_tick_o(tick), .ext_bit_clk_i(ext_clk), .rx_serial_in_i(rxd),
    .sclk_o(sclk), .sclk_oe_o(sclk_oe), .frame_sync_pin_o(fs),
    .frame_sync_pin_oe_o(fs_oe), .tx_serial_out_o(txd),
    .tx_serial_out_oe_o(tx_oe), .pins_to_alt_o(p_alt),
    .pins_to_pin_share_o(p_share));

  codec_link_model codec_link_model_inst (
    .sclk_i(sclk), .fsync_i(fs), .tx_i(txd), .reply_i(REPLY), .rx_o(rxd),
    .got_o(got), .sub1_high_o(sub1), .frames_o(frames),
    .frame_bits_o(fbits), .frame_ns_o(fns));

  task automatic check(input string what, input logic [63:0] exp,
                       input logic [63:0] seen);
    tests_run++;
    if (seen !== exp) begin
      $display("ERROR %s expected %h seen %h", what, exp, seen);
      err_count++;
    end
  endtask : check

  // Bounded by the watchdog, which ends the run if frames stop
  task automatic wait_frame(input int n);
    int k;
    k = frames + n;
    while (frames < k) @(posedge clock_i);
    #1;
  endtask : wait_frame

  // Frame period from the oscillator, multiplier and divider
  task automatic check_rate(input int div);
    real exp;
    exp = 128.0 * div * 1.0e9 / (1.0 * `CFP_OSC_HZ * `CFP_OSC_MULT);
    check("frame_ns", 1, (fns > exp - 20.0) && (fns < exp + 20.0));
  endtask : check_rate

  task end_sim;
    $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_sim

  initial begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end

  // Free-running off-chip bit clock, 24 ns, edges away from posedges
  initial begin
    ext_clk = 1'b0;
    forever #12 ext_clk = ~ext_clk;
  end

  // Audio rate counter activity (tick[0] only), counted over the whole run
  always @(posedge clock_i) if (tick[0] === 1'b1) ticks++;

  // The run needs about 65 us of frames; the 150 us limit is over twice that
  initial begin
    #150000;
    err_count++;
    end_sim();
  end

  initial begin
    {sys_rst_i, enable_i, alt_en, hi_rate, sec_en, ext_sel} = 6'h20;
    {cmd_wr, ack, atv, ttv, arr, trr} = 6'h00;
    {atd, ttd, ticks, err_count, tests_run} = '0;
    cmd = '0;
    repeat (2) @(posedge clock_i);
    #1 sys_rst_i = 1'b0;
    @(posedge clock_i);
    #1;
    check("pin_share", 1, p_share);
    check("oe_idle", 0, {sclk_oe, fs_oe, tx_oe});
    // Prime both transmit FIFOs and queue a register read before enable
    {atv, ttv, atd, ttd} = {2'b11, 16'h1234, 16'h5678};
    do @(posedge clock_i); while (!(atr === 1'b1 && ttr === 1'b1));
    #1 {atv, ttv} = 2'b00;
    cmd = '{write: 1'b0, addr: 4'h5, data: 16'h0000};
    cmd_wr = 1'b1;
    @(posedge clock_i);
    #1 cmd_wr = 1'b0;
    check("cmd_pending", 1, cmd_pend);
    {enable_i, sec_en} = 2'b11;
    wait_frame(1);
    check("frame1", EXP1, got);
    check("cmd_done", 0, cmd_pend);
    check("pins_owned", 2'b01, {p_share, sclk_oe});
    wait_frame(1);
    check("frame2", EXP1 & ~64'h0000_0000_C000_0000, got);
    check("frame_bits", 128, fbits);
    check_rate(`CFP_DIV_LOW_RATE);
    check("audio_rx", {1'b1, 16'hA5C3}, {arv, ard});
    check("tel_rx", {1'b1, 16'h3C5A}, {trv, trd});
    check("resp", {1'b1, 4'h9, 16'hBEEF}, {resp_v, resp.addr, resp.data});
    check("rate_tick", 1, ticks > 0);
    {arr, trr, ack} = 3'b111;
    @(posedge clock_i);
    #1 {arr, trr, ack} = 3'b000;
    check("resp_ack", 0, resp_v);
    alt_en = 1'b1;
    repeat (3) @(posedge clock_i);
    #1;
    check("alt_blocked", 0, p_alt);
    enable_i = 1'b0;
    repeat (3) @(posedge clock_i);
    #1;
    check("alt_free", 1, p_alt);
    {hi_rate, enable_i} = 2'b11;
    wait_frame(2);
    check("frame_bits_hi", 128, fbits);
    check_rate(`CFP_DIV_HIGH_RATE);
    // Off-chip bit clock, with a codec register write queued while idle
    cmd = '{write: 1'b1, addr: 4'hA, data: 16'hC0DE};
    {cmd_wr, enable_i} = 2'b10;
    @(posedge clock_i);
    #1 {cmd_wr, ext_sel, enable_i} = 3'b011;
    wait_frame(1);
    check("frame_ext", EXP2, got);
    // Nine more frames overfill the receive FIFOs, nobody drains them
    wait_frame(9);
    check("frame_bits_ext", 128, fbits);
    check("frame_ns_ext", 1, fns > 3052.0 && fns < 3092.0);
    check("rx_overrun", 1, ovr);
    check("resp_write", 0, resp_v);
    check("sub1_low", 0, sub1);
    end_sim();
  end
endmodule : codec_frame_port_bench
